// ---- logic/serial_port_pkg.sv ----
package serial_port_pkg;

  // Register offsets (byte addresses on the plain register port).
  localparam logic [11:0] ADDR_CTRL_MAIN = 12'h025;
  localparam logic [11:0] ADDR_STATUS = 12'h025;
  localparam logic [11:0] ADDR_CTRL_AUX = 12'h026;
  localparam logic [11:0] ADDR_DATA_BUF = 12'hF9B;

  // Main control field positions.
  localparam int CM_TX_ENABLE = 7;
  localparam int CM_RX_ENABLE = 6;
  localparam int CM_TX_STOP_LEN = 5;
  localparam int CM_PARITY_EVEN = 4;
  localparam int CM_PARITY_ENABLE = 3;
  localparam int CM_BAUD_LSB = 0;

  // Auxiliary control field positions.
  localparam int CA_GLITCH_LSB = 1;
  localparam int CA_RX_STOP_LEN = 0;

  // Status field positions.
  localparam int ST_PARITY_ERR = 7;
  localparam int ST_FRAME_ERR = 6;
  localparam int ST_OVERRUN_ERR = 5;
  localparam int ST_RX_FULL = 4;
  localparam int ST_TX_DONE = 3;
  localparam int ST_TX_EMPTY = 2;

  // Reset values.
  localparam logic [7:0] CTRL_MAIN_RESET = 8'h00;
  localparam logic [2:0] CTRL_AUX_RESET = 3'h0;
  localparam logic [7:0] DATA_BUF_RESET = 8'h00;

  // Baud dividers in system clock periods per transfer clock tick.
  localparam logic [8:0] DIV_SEL0 = 9'd13;
  localparam logic [8:0] DIV_SEL1 = 9'd26;
  localparam logic [8:0] DIV_SEL2 = 9'd52;
  localparam logic [8:0] DIV_SEL3 = 9'd104;
  localparam logic [8:0] DIV_SEL4 = 9'd208;
  localparam logic [8:0] DIV_SEL5 = 9'd416;
  localparam logic [8:0] DIV_SEL7 = 9'd96;
  localparam logic [2:0] BAUD_TIMER = 3'b110;

  // Oversampling: ticks per bit and majority sample points.
  localparam logic [3:0] TICKS_LAST = 4'hF;
  localparam logic [3:0] SAMPLE_A = 4'h7;
  localparam logic [3:0] SAMPLE_B = 4'h8;
  localparam logic [3:0] SAMPLE_C = 4'h9;

  // Glitch filter: stable-time thresholds in system clocks.
  localparam logic [6:0] GLITCH_T1 = 7'd31;
  localparam logic [6:0] GLITCH_T2 = 7'd63;
  localparam logic [6:0] GLITCH_T3 = 7'd127;

  // Shared frame format carried to both shifters.
  typedef struct packed {
    logic parity_enable;
    logic parity_even;
    logic tx_stop_len;
    logic rx_stop_len;
  } frame_cfg_s;

  // Result of one received frame.
  typedef struct packed {
    logic [7:0] data;
    logic parity_err;
    logic frame_err;
  } rx_result_s;

endpackage

// ---- logic/rx_glitch_filter.sv ----
`timescale 1ns/1ps
// Receive-line noise filter: the output follows the input only after the
// input has held a new level for the selected number of system clocks.
module rx_glitch_filter (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Control.
  input wire logic [1:0] sel_i,
  // Line.
  input wire logic rx_i,
  output logic rx_o
);

  logic [6:0] cnt_q;
  logic [6:0] limit;

  // Threshold per setting; zero means follow the input one clock later, unfiltered.
  always_comb begin
    unique case (sel_i)
      2'b00: limit = 7'h00;
      2'b01: limit = serial_port_pkg::GLITCH_T1;
      2'b10: limit = serial_port_pkg::GLITCH_T2;
      2'b11: limit = serial_port_pkg::GLITCH_T3;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= 7'h00;
      rx_o <= 1'b1;
    end else if (rx_i == rx_o) begin
      cnt_q <= 7'h00;
    end else if (cnt_q >= limit) begin
      rx_o <= rx_i;
      cnt_q <= 7'h00;
    end else begin
      cnt_q <= cnt_q + 7'h01;
    end
  end

endmodule

// ---- logic/baud_tick_gen.sv ----
`timescale 1ns/1ps
// Transfer clock generator: one-cycle tick per transfer clock period.
module baud_tick_gen (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Control.
  input wire logic [2:0] sel_i,
  input wire logic timer5_match_event_i,
  // Tick.
  output logic tick_o
);

  logic [8:0] cnt_q;
  logic [8:0] div;

  always_comb begin
    unique case (sel_i)
      3'b000: div = serial_port_pkg::DIV_SEL0;
      3'b001: div = serial_port_pkg::DIV_SEL1;
      3'b010: div = serial_port_pkg::DIV_SEL2;
      3'b011: div = serial_port_pkg::DIV_SEL3;
      3'b100: div = serial_port_pkg::DIV_SEL4;
      3'b101: div = serial_port_pkg::DIV_SEL5;
      3'b110: div = serial_port_pkg::DIV_SEL7;
      3'b111: div = serial_port_pkg::DIV_SEL7;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= 9'h000;
      tick_o <= 1'b0;
    end else if (sel_i == serial_port_pkg::BAUD_TIMER) begin
      cnt_q <= 9'h000;
      tick_o <= timer5_match_event_i;
    end else if (cnt_q >= div - 9'h001) begin
      cnt_q <= 9'h000;
      tick_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 9'h001;
      tick_o <= 1'b0;
    end
  end

endmodule

// ---- logic/async_serial_port.sv ----
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module async_serial_port (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Register port.
  input wire logic [11:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Timer event.
  input wire logic timer5_match_event_i,
  // Serial lines.
  input wire logic rxd_i,
  output logic txd_o,
  // Interrupt events.
  output logic tx_irq_o,
  output logic rx_irq_o
);

  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA = 5'b00100,
    TX_PAR = 5'b01000,
    TX_STOP = 5'b10000
  } tx_state_e;

  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA = 5'b00100,
    RX_PAR = 5'b01000,
    RX_STOP = 5'b10000
  } rx_state_e;

  logic [7:0] ctrl_main_q;
  logic [2:0] ctrl_aux_q;
  logic [7:0] rx_buf_q;
  logic [7:0] tx_buf_q;
  logic parity_err_q, frame_err_q, overrun_err_q, rx_full_q;
  logic tx_done_q, tx_empty_q;
  logic tx_pending_q;
  logic status_read_q;
  logic tick;
  logic rx_filt;
  serial_port_pkg::frame_cfg_s cfg;
  tx_state_e tx_state_q;
  rx_state_e rx_state_q;
  logic [3:0] tx_tick_q, rx_tick_q;
  logic [2:0] tx_bit_q, rx_bit_q;
  logic [7:0] tx_shift_q, rx_shift_q;
  logic tx_stop2_q, rx_stop2_q;
  logic [1:0] votes_q;
  logic rx_par_q;
  logic rx_done_q;
  serial_port_pkg::rx_result_s rx_res_q;
  logic wr_main, wr_aux, wr_data, rd_stat, rd_data;
  logic tx_launch, bit_val;

  // Address decode; control and status share an address by direction.
  assign wr_main = wr_i && addr_i == serial_port_pkg::ADDR_CTRL_MAIN;
  assign wr_aux = wr_i && addr_i == serial_port_pkg::ADDR_CTRL_AUX;
  assign wr_data = wr_i && addr_i == serial_port_pkg::ADDR_DATA_BUF;
  assign rd_stat = rd_i && addr_i == serial_port_pkg::ADDR_STATUS;
  assign rd_data = rd_i && addr_i == serial_port_pkg::ADDR_DATA_BUF;

  assign cfg.parity_enable = ctrl_main_q[serial_port_pkg::CM_PARITY_ENABLE];
  assign cfg.parity_even = ctrl_main_q[serial_port_pkg::CM_PARITY_EVEN];
  assign cfg.tx_stop_len = ctrl_main_q[serial_port_pkg::CM_TX_STOP_LEN];
  assign cfg.rx_stop_len = ctrl_aux_q[serial_port_pkg::CA_RX_STOP_LEN];

  baud_tick_gen u_baud (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .sel_i(ctrl_main_q[serial_port_pkg::CM_BAUD_LSB +: 3]),
    .timer5_match_event_i(timer5_match_event_i),
    .tick_o(tick)
  );

  rx_glitch_filter u_filt (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .sel_i(ctrl_aux_q[serial_port_pkg::CA_GLITCH_LSB +: 2]),
    .rx_i(rxd_i),
    .rx_o(rx_filt)
  );

  // Control registers; write-only.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_main_q <= serial_port_pkg::CTRL_MAIN_RESET;
      ctrl_aux_q <= serial_port_pkg::CTRL_AUX_RESET;
    end else begin
      if (wr_main) ctrl_main_q <= wdata_i;
      if (wr_aux) ctrl_aux_q <= wdata_i[2:0];
    end
  end

  // Tracks a status read so a following buffer access may clear flags.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) status_read_q <= 1'b0;
    else if (rd_stat) status_read_q <= 1'b1;
    else if (rd_data || wr_data) status_read_q <= 1'b0;
  end

  // Read data, one cycle after the strobe; unmapped reads return zero.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_stat) begin
      rdata_o <= {parity_err_q, frame_err_q, overrun_err_q, rx_full_q,
                  tx_done_q, tx_empty_q, 2'b00};
    end else if (rd_data) begin
      rdata_o <= rx_buf_q;
    end else begin
      rdata_o <= 8'h00;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_buf_q <= serial_port_pkg::DATA_BUF_RESET;
      tx_pending_q <= 1'b0;
    end else if (wr_data && status_read_q) begin
      tx_buf_q <= wdata_i;
      tx_pending_q <= 1'b1;
    end else if (tx_launch) begin
      tx_pending_q <= 1'b0;
    end
  end

  assign tx_launch = tx_state_q == TX_IDLE && tx_pending_q && tick &&
                     ctrl_main_q[serial_port_pkg::CM_TX_ENABLE];

  // Transmit flags; the launch event wins over the write clear.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_empty_q <= 1'b1;
      tx_done_q <= 1'b1;
      tx_irq_o <= 1'b0;
    end else begin
      tx_irq_o <= tx_launch;
      if (tx_launch) tx_empty_q <= 1'b1;
      else if (wr_data && status_read_q) tx_empty_q <= 1'b0;
      if (tx_launch) tx_done_q <= 1'b0;
      else if (tx_state_q == TX_STOP && tick && tx_tick_q ==
               serial_port_pkg::TICKS_LAST && !tx_stop2_q &&
               !tx_pending_q) tx_done_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_state_q <= TX_IDLE;
      tx_tick_q <= 4'h0;
      tx_bit_q <= 3'h0;
      tx_shift_q <= 8'h00;
      tx_stop2_q <= 1'b0;
      txd_o <= 1'b1;
    end else if (tick) begin
      tx_tick_q <= tx_tick_q + 4'h1;
      unique case (tx_state_q)
        TX_IDLE: begin
          tx_tick_q <= 4'h0;
          txd_o <= 1'b1;
          if (tx_launch) begin
            tx_shift_q <= tx_buf_q;
            tx_state_q <= TX_START;
            txd_o <= 1'b0;
          end
        end
        TX_START: begin
          if (tx_tick_q == serial_port_pkg::TICKS_LAST) begin
            tx_state_q <= TX_DATA;
            tx_bit_q <= 3'h0;
            txd_o <= tx_shift_q[0];
          end
        end
        TX_DATA: begin
          if (tx_tick_q == serial_port_pkg::TICKS_LAST) begin
            tx_bit_q <= tx_bit_q + 3'h1;
            txd_o <= tx_shift_q[tx_bit_q + 3'h1];
            if (tx_bit_q == 3'h7) begin
              if (cfg.parity_enable) begin
                tx_state_q <= TX_PAR;
                txd_o <= ^tx_shift_q ^ ~cfg.parity_even;
              end else begin
                tx_state_q <= TX_STOP;
                txd_o <= 1'b1;
              end
              tx_stop2_q <= cfg.tx_stop_len;
            end
          end
        end
        TX_PAR: begin
          if (tx_tick_q == serial_port_pkg::TICKS_LAST) begin
            tx_state_q <= TX_STOP;
            txd_o <= 1'b1;
          end
        end
        TX_STOP: begin
          if (tx_tick_q == serial_port_pkg::TICKS_LAST) begin
            if (tx_stop2_q) tx_stop2_q <= 1'b0;
            else tx_state_q <= TX_IDLE;
          end
        end
      endcase
    end
  end

  assign bit_val = votes_q[1] || (votes_q[0] && rx_filt);

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_state_q <= RX_IDLE;
      rx_tick_q <= 4'h0;
      rx_bit_q <= 3'h0;
      rx_shift_q <= 8'h00;
      votes_q <= 2'b00;
      rx_par_q <= 1'b0;
      rx_stop2_q <= 1'b0;
      rx_done_q <= 1'b0;
      rx_res_q <= '0;
    end else begin
      rx_done_q <= 1'b0;
      if (tick) begin
        rx_tick_q <= rx_tick_q + 4'h1;
        if (rx_tick_q == serial_port_pkg::SAMPLE_A)
          votes_q <= {1'b0, rx_filt};
        if (rx_tick_q == serial_port_pkg::SAMPLE_B)
          votes_q <= {votes_q[0] & rx_filt, votes_q[0] | rx_filt};
        unique case (rx_state_q)
          RX_IDLE: begin
            rx_tick_q <= 4'h0;
            if (!rx_filt && !overrun_err_q &&
                ctrl_main_q[serial_port_pkg::CM_RX_ENABLE])
              rx_state_q <= RX_START;
          end
          RX_START: begin
            if (rx_tick_q == serial_port_pkg::SAMPLE_C) begin
              if (bit_val) rx_state_q <= RX_IDLE;
            end else if (rx_tick_q == serial_port_pkg::TICKS_LAST) begin
              rx_state_q <= RX_DATA;
              rx_bit_q <= 3'h0;
            end
          end
          RX_DATA: begin
            if (rx_tick_q == serial_port_pkg::SAMPLE_C)
              rx_shift_q <= {bit_val, rx_shift_q[7:1]};
            if (rx_tick_q == serial_port_pkg::TICKS_LAST) begin
              rx_bit_q <= rx_bit_q + 3'h1;
              if (rx_bit_q == 3'h7) begin
                rx_state_q <= cfg.parity_enable ? RX_PAR : RX_STOP;
                rx_stop2_q <= cfg.rx_stop_len;
                rx_res_q.frame_err <= 1'b0;
                rx_res_q.parity_err <= 1'b0;
              end
            end
          end
          RX_PAR: begin
            if (rx_tick_q == serial_port_pkg::SAMPLE_C)
              rx_par_q <= bit_val;
            if (rx_tick_q == serial_port_pkg::TICKS_LAST) begin
              rx_state_q <= RX_STOP;
              rx_res_q.parity_err <=
                (^rx_shift_q ^ ~cfg.parity_even) != rx_par_q;
            end
          end
          RX_STOP: begin
            if (rx_tick_q == serial_port_pkg::SAMPLE_C) begin
              if (!bit_val) rx_res_q.frame_err <= 1'b1;
              if (rx_stop2_q) begin
                rx_stop2_q <= 1'b0;
              end else begin
                rx_state_q <= RX_IDLE;
                rx_done_q <= 1'b1;
                rx_res_q.data <= rx_shift_q;
              end
            end
          end
        endcase
      end
    end
  end

  // Receive buffer and flags; a frame landing on the clearing read wins.
  // read-after-status clear.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_buf_q <= serial_port_pkg::DATA_BUF_RESET;
      rx_full_q <= 1'b0;
      overrun_err_q <= 1'b0;
      parity_err_q <= 1'b0;
      frame_err_q <= 1'b0;
      rx_irq_o <= 1'b0;
    end else begin
      rx_irq_o <= 1'b0;
      if (rd_data && status_read_q) begin
        rx_full_q <= 1'b0;
        overrun_err_q <= 1'b0;
        parity_err_q <= 1'b0;
        frame_err_q <= 1'b0;
      end
      if (rx_done_q) begin
        if (rx_full_q && !(rd_data && status_read_q)) begin
          overrun_err_q <= 1'b1;
        end else begin
          rx_buf_q <= rx_res_q.data;
          rx_full_q <= 1'b1;
          parity_err_q <= rx_res_q.parity_err;
          frame_err_q <= rx_res_q.frame_err;
          rx_irq_o <= 1'b1;
        end
      end
    end
  end

endmodule

// ---- test/serial_remote.sv ----
`timescale 1ns/1ps
module serial_remote #(
  parameter int BIT = 208
) (
  // Clock.
  input wire logic sys_clk_i,
  // Lines seen from the remote station.
  input wire logic txd_i,
  output logic rxd_o,
  // Last captured frame and start stamps in clocks.
  output logic [8:0] got_o,
  output int cnt_o,
  output int stamp_o,
  output int prev_o
);
  // The line idles high between frames.
  initial rxd_o = 1'b1;

  // Samples each frame at mid bit: eight data bits, then one more bit.
  // frame capture
  initial begin
    cnt_o = 0;
    stamp_o = 0;
    prev_o = 0;
    got_o = 9'h000;
    forever begin
      @(negedge txd_i);
      prev_o = stamp_o;
      stamp_o = int'($time / 8);
      repeat (BIT / 2) @(posedge sys_clk_i);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT) @(posedge sys_clk_i);
        got_o[i] = txd_i;
      end
      cnt_o = cnt_o + 1;
    end
  end

  // Sends one frame, LSB first; flaws flip parity or drop the last stop.
  // frame build
  task automatic send(input logic [7:0] d, input logic pe, input logic ev,
                      input logic two, input logic badp, input logic bads);
    logic [11:0] f;
    int n;
    f = {2'b11, pe ? (^d ^ ~ev ^ badp) : 1'b1, d, 1'b0};
    n = 10 + int'(pe) + int'(two);
    if (bads) f[n - 1] = 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk_i);
      rxd_o <= f[i];
      repeat (BIT - 1) @(posedge sys_clk_i);
    end
    @(posedge sys_clk_i);
    rxd_o <= 1'b1;
  endtask

  // Pulls the line low for a short noise pulse.
  task automatic pulse(input int n);
    @(posedge sys_clk_i);
    rxd_o <= 1'b0;
    repeat (n) @(posedge sys_clk_i);
    rxd_o <= 1'b1;
  endtask
endmodule

// ---- test/async_serial_port_chk.sv ----
`timescale 1ns/1ps
module async_serial_port_chk (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Register port.
  input wire logic [11:0] addr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // Serial line and events.
  input wire logic txd_o,
  input wire logic tx_irq_o,
  input wire logic rx_irq_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);

  // A start bit begins with a fall and lasts well beyond eight clocks.
  sequence s_fall;
    $fell(txd_o);
  endsequence
  sequence s_low;
    !txd_o [*8];
  endsequence
  a_start_low: assert property (s_fall |-> s_low)
    else $error("start bit shorter than eight clocks");
  a_bit_stable: assert property ($changed(txd_o) |=> $stable(txd_o) [*8])
    else $error("serial bit shorter than eight clocks");
  a_irq_start: assert property (tx_irq_o |-> ##[0:2] !txd_o)
    else $error("transmit event without start bit");
  a_tx_pulse: assert property (tx_irq_o |=> !tx_irq_o)
    else $error("transmit event longer than one cycle");
  a_rx_pulse: assert property (rx_irq_o |=> !rx_irq_o)
    else $error("receive event longer than one cycle");
  a_status_low: assert property ($past(rd_i && addr_i ==
    serial_port_pkg::ADDR_STATUS) |-> rdata_o[1:0] == 2'h0)
    else $error("status low bits not zero");
  a_wo_zero: assert property ($past(rd_i && addr_i !=
    serial_port_pkg::ADDR_STATUS && addr_i != serial_port_pkg::ADDR_DATA_BUF)
    |-> rdata_o == 8'h00)
    else $error("read of unreadable place not zero");
  a_rd_quiet: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside the answer cycle");
endmodule

bind async_serial_port async_serial_port_chk CHK (
  .sys_clk_i(sys_clk_i),
  .nrst_i(nrst_i),
  .addr_i(addr_i),
  .rd_i(rd_i),
  .rdata_o(rdata_o),
  .txd_o(txd_o),
  .tx_irq_o(tx_irq_o),
  .rx_irq_o(rx_irq_o)
);

// ---- test/async_serial_port_tb.sv ----
`timescale 1ns/1ps
module async_serial_port_tb;
  localparam int BIT = 208;
  localparam logic [11:0] A_ST = serial_port_pkg::ADDR_STATUS;
  localparam logic [11:0] A_AX = serial_port_pkg::ADDR_CTRL_AUX;
  localparam logic [11:0] A_BUF = serial_port_pkg::ADDR_DATA_BUF;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [11:0] addr_i = 12'h000;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic timer5_match_event_i = 1'b0;
  logic rxd_i, txd_o, tx_irq_o, rx_irq_o;
  logic [7:0] rdata_o;
  logic [8:0] got;
  int cnt, stamp, prev, tdiv = 0, tx_seen = 0, rx_seen = 0;
  int mismatches = 0, checks_done = 0;

  async_serial_port DUT (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .timer5_match_event_i(timer5_match_event_i),
    .rxd_i(rxd_i), .txd_o(txd_o), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o));
  serial_remote #(.BIT(BIT)) REM (.sys_clk_i(sys_clk_i), .txd_i(txd_o),
    .rxd_o(rxd_i), .got_o(got), .cnt_o(cnt), .stamp_o(stamp), .prev_o(prev));

  // Clock of 8 ns.
  initial begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  // Timer match pulse every fifth clock; counts the event pulses.
  always @(posedge sys_clk_i) begin
    tdiv <= (tdiv == 4) ? 0 : tdiv + 1;
    timer5_match_event_i <= (tdiv == 4);
    if (tx_irq_o === 1'b1) tx_seen <= tx_seen + 1;
    if (rx_irq_o === 1'b1) rx_seen <= rx_seen + 1;
  end

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    @(negedge sys_clk_i);
    d = rdata_o;
  endtask

  task automatic rchk(input string n, input logic [11:0] a,
                      input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(n, d & m, e);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  task automatic t_reset();
    rchk("status", A_ST, 8'hFF, 8'h0C);
    rchk("rx buffer", A_BUF, 8'hFF, 8'h00);
    rchk("unmapped", 12'h000, 8'hFF, 8'h00);
  endtask

  task automatic t_hold();
    logic [7:0] d;
    wr(12'h025, 8'h80);
    idle(3000);
    chk("stale byte", tx_seen, 0);
    wr(A_BUF, 8'h5A);
    idle(3000);
    chk("write without status", tx_seen, 0);
    rd(A_ST, d);
    wr(A_BUF, 8'h3C);
    idle(400);
    wr(12'h025, 8'h00);
    idle(BIT * 11);
    chk("frame after disable", cnt, 1);
    chk("data", got, 9'h13C);
  endtask

  task automatic t_formats();
    logic [2:0] fm [4] = '{3'b000, 3'b100, 3'b110, 3'b011};
    logic [7:0] d, dv;
    logic pe, ev, two, par;
    int n0, k;
    for (int i = 0; i < 4; i++) begin
      {pe, ev, two} = fm[i];
      dv = 8'hA5 + 8'(i * 37);
      n0 = tx_seen;
      wr(12'h025, {2'b10, two, ev, pe, 3'b000});
      rd(A_ST, d);
      wr(A_BUF, 8'hFF);
      for (k = 0; k < 2000 && tx_seen == n0; k++) idle(1);
      rchk("empty on start", A_ST, 8'h04, 8'h04);
      wr(A_BUF, dv);
      idle(BIT * 24);
      chk("frames", tx_seen - n0, 2);
      chk("data", got[7:0], dv);
      par = pe ? (^dv ^ ~ev) : 1'b1;
      chk("parity", got[8], par);
      // Back-to-back frames leave one idle tick between them.
      chk("length", stamp - prev, BIT * (10 + pe + two) + BIT / 16);
      rchk("done", A_ST, 8'h0C, 8'h0C);
    end
  endtask

  task automatic t_rx();
    logic [7:0] d;
    int n0;
    rd(A_BUF, d);
    wr(12'h025, 8'h58);
    wr(A_AX, 8'h00);
    n0 = rx_seen;
    REM.send(8'h96, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    idle(60);
    chk("rx event", rx_seen - n0, 1);
    rchk("buffer direct", A_BUF, 8'hFF, 8'h96);
    rchk("flags kept", A_ST, 8'hF0, 8'h10);
    rchk("buffer", A_BUF, 8'hFF, 8'h96);
    rchk("flags clear", A_ST, 8'hF0, 8'h00);
    REM.send(8'h96, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    idle(60);
    rchk("parity error", A_ST, 8'hE0, 8'h80);
    rd(A_BUF, d);
    wr(A_AX, 8'h01);
    REM.send(8'h21, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    idle(60);
    rchk("frame error", A_ST, 8'hE0, 8'h40);
    rd(A_BUF, d);
    rchk("errors clear", A_ST, 8'hF0, 8'h00);
  endtask

  task automatic t_overrun();
    logic [7:0] d;
    int n0;
    rd(A_BUF, d);
    wr(A_AX, 8'h00);
    n0 = rx_seen;
    REM.send(8'h11, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    REM.send(8'h22, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    idle(60);
    chk("loads", rx_seen - n0, 1);
    rchk("overrun", A_ST, 8'hF0, 8'h30);
    rchk("kept byte", A_BUF, 8'hFF, 8'h11);
    rchk("overrun clear", A_ST, 8'hF0, 8'h00);
  endtask

  task automatic t_glitch();
    logic [7:0] d;
    int n0;
    rd(A_BUF, d);
    wr(A_AX, 8'h06);
    n0 = rx_seen;
    REM.pulse(120);
    idle(BIT * 12);
    chk("noise dropped", rx_seen - n0, 0);
    wr(A_AX, 8'h02);
    REM.send(8'h5C, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    idle(100);
    chk("filtered frame", rx_seen - n0, 1);
    rd(A_ST, d);
    rchk("filtered data", A_BUF, 8'hFF, 8'h5C);
  endtask

  task automatic t_baud();
    logic [2:0] bs [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7, 3'h6};
    int per [8] = '{13, 26, 52, 104, 208, 416, 96, 5};
    int k, w;
    for (int i = 0; i < 8; i++) begin
      // A reset pulse cuts the last frame, so each rate costs one start bit.
      idle(1);
      nrst_i <= 1'b0;
      idle(2);
      nrst_i <= 1'b1;
      rchk("status after cut", A_ST, 8'hFF, 8'h0C);
      wr(12'h025, {5'b00000, bs[i]});
      wr(12'h025, {5'b10000, bs[i]});
      wr(A_BUF, 8'h01);
      for (k = 0; k < 20000 && txd_o !== 1'b0; k++) @(negedge sys_clk_i);
      for (w = 0; w < 20000 && txd_o === 1'b0; w++) @(negedge sys_clk_i);
      chk("start width", w, per[i] * 16);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence.
  initial begin
    repeat (20) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_hold();
    t_formats();
    t_rx();
    t_overrun();
    t_glitch();
    t_baud();
    close_out();
  end

  // Watchdog against a hang.
  initial begin
    repeat (80000) @(posedge sys_clk_i);
    mismatches++;
    close_out();
  end
endmodule
